// ### inc/cise_map.svh
// Offsets, field positions, reset values and timing counts of the instruction subset executor.
`ifndef CISE_MAP_SVH
`define CISE_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define CISE_CTRL_OFF      12'h000
`define CISE_STATUS_OFF    12'h004
`define CISE_ACC_OFF       12'h008
`define CISE_FILE_ADDR_OFF 12'h00C
`define CISE_FILE_DATA_OFF 12'h010
`define CISE_PC_OFF        12'h014
`define CISE_STACK_OFF     12'h018
`define CISE_WDT_OFF       12'h01C

// ****************************************
// Field positions
// ****************************************
`define CISE_CTRL_OP_LSB   0
`define CISE_CTRL_DEST_BIT 4
`define CISE_CTRL_WAKE_BIT 5
`define CISE_CTRL_LIT_LSB  8
`define CISE_CTRL_FA_LSB   16
`define CISE_ST_C    0
`define CISE_ST_DC   1
`define CISE_ST_Z    2
`define CISE_ST_PD   3
`define CISE_ST_TO   4
`define CISE_ST_BUSY 5
`define CISE_ST_SLP  6

// ****************************************
// Reset values, timing and storage depths
// ****************************************
`define CISE_STATUS_RST 5'h18
`define CISE_RET_CYCLES 2
`define CISE_FILE_DEPTH 128
`define CISE_STACK_DEPTH 16

`endif

// ### inc/cise_pkg.sv
// Types shared by the instruction subset executor.
package cise_pkg;
	typedef enum logic [2:0] {
		CISE_OP_NONE   = 3'h0,
		CISE_OP_RETURN = 3'h1,
		CISE_OP_RRC    = 3'h2,
		CISE_OP_RLC    = 3'h3,
		CISE_OP_SLEEP  = 3'h4,
		CISE_OP_LSUB   = 3'h5
	} cise_op_e;

	typedef enum logic [3:0] {
		CISE_ST_IDLE = 4'b0001,
		CISE_ST_RET2 = 4'b0010,
		CISE_ST_SLP  = 4'b0100,
		CISE_ST_DONE = 4'b1000
	} cise_state_e;

	// Field order matches the status word, so the status reset value casts straight in.
	typedef struct packed {
		logic       to_n;
		logic       pd_n;
		logic       z;
		logic       dc;
		logic       c;
	} cise_flags_s;

	typedef struct packed {
		logic [7:0] result;
		logic       carry;
	} cise_rot_s;
endpackage : cise_pkg

// ### src/cise_rotator.sv
// Nine-bit rotate through carry, either direction.
`timescale 1ns/1ps
module cise_rotator (
	input  wire logic             left_i,
	input  wire logic [7:0]       data_i,
	input  wire logic             carry_i,
	output cise_pkg::cise_rot_s   rot_o
);
	import cise_pkg::*;

	always_comb begin
		if (left_i) begin
			rot_o = '{result: {data_i[6:0], carry_i}, carry: data_i[7]};
		end else begin
			rot_o = '{result: {carry_i, data_i[7:1]}, carry: data_i[0]};
		end
	end
endmodule : cise_rotator

// ### src/cise_core.sv
// APB-controlled executor for return, rotates, sleep and literal subtract.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "cise_map.svh"

// Behaviour
// - return pops stack into program counter, no flags
// - return takes two instruction cycles
// - rotate right moves carry into bit seven
// - destination bit picks accumulator or file register
// - rotate left is one cycle, carry only
// - sleep clears power-down flag, sets timeout flag
// - sleep zeroes watchdog counter and prescaler
// - sleep halts execution until wake
// - literal minus accumulator into accumulator
// - carry and half carry mean no borrow
module cise_core #(
	parameter int FILE_DEPTH  = `CISE_FILE_DEPTH,
	parameter int STACK_DEPTH = `CISE_STACK_DEPTH
) (
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             sleeping_o
);
	import cise_pkg::*;

	localparam int SP_W = $clog2(STACK_DEPTH);

	// ****************************************
	// State
	// ****************************************
	cise_state_e       state;
	cise_state_e       next_state;
	cise_flags_s       flags;
	cise_flags_s       next_flags;
	logic [7:0]        acc;
	logic [7:0]        next_acc;
	logic [12:0]       pc;
	logic [12:0]       next_pc;
	logic [SP_W-1:0]   sp;
	logic [SP_W-1:0]   next_sp;
	logic [12:0]       stack [STACK_DEPTH];
	logic [7:0]        file_q [FILE_DEPTH];
	logic [7:0]        wdt_cnt;
	logic [7:0]        next_wdt_cnt;
	logic [7:0]        wdt_pre;
	logic [7:0]        next_wdt_pre;
	logic [6:0]        file_addr;
	logic [6:0]        next_file_addr;
	logic              file_we;
	logic [6:0]        file_wa;
	logic [7:0]        file_wd;
	logic              stack_we;
	logic [12:0]       stack_wd;
	logic [31:0]       next_prdata;
	logic              next_slverr;

	logic              wr_acc;
	logic              rd_acc;
	cise_op_e          op;
	logic              dest;
	logic [7:0]        lit;
	logic [6:0]        fa;
	cise_rot_s         rot;
	logic [8:0]        diff;
	logic [4:0]        ndiff;
	logic              wdt_tick;

	assign wr_acc = psel_i && penable_i && pwrite_i;
	assign rd_acc = psel_i && penable_i && !pwrite_i;
	assign op     = cise_op_e'(pwdata_i[`CISE_CTRL_OP_LSB +: 3]);
	assign dest   = pwdata_i[`CISE_CTRL_DEST_BIT];
	assign lit    = pwdata_i[`CISE_CTRL_LIT_LSB +: 8];
	assign fa     = pwdata_i[`CISE_CTRL_FA_LSB +: 7];
	assign diff   = {1'b0, lit} - {1'b0, acc};
	assign ndiff  = {1'b0, lit[3:0]} - {1'b0, acc[3:0]};
	// The prescaler is the divider; its wrap is the one-cycle tick that advances the counter.
	assign wdt_tick = (wdt_pre == 8'hFF);

	// ****************************************
	// Rotator
	// ****************************************
	cise_rotator u_cise_rotator (
		.left_i  (op == CISE_OP_RLC),
		.data_i  (file_q[fa]),
		.carry_i (flags.c),
		.rot_o   (rot)
	);

	// A write to the control register issues one instruction; the busy cycle of a return
	// or a sleeping core stretches the APB answer, so software never overlaps instructions.
	assign pready_o   = !(wr_acc && (paddr_i == `CISE_CTRL_OFF) && (state != CISE_ST_IDLE)
		&& !(state == CISE_ST_SLP && pwdata_i[`CISE_CTRL_WAKE_BIT]));
	assign sleeping_o = (state == CISE_ST_SLP);

	// ****************************************
	// Execution
	// ****************************************
	always_comb begin
		next_state     = state;
		next_flags     = flags;
		next_acc       = acc;
		next_pc        = pc;
		next_sp        = sp;
		next_wdt_cnt   = wdt_cnt + {7'h00, wdt_tick};
		next_wdt_pre   = wdt_pre + 8'h01;
		next_file_addr = file_addr;
		file_we        = 1'b0;
		file_wa        = file_addr;
		file_wd        = pwdata_i[7:0];
		stack_we       = 1'b0;
		stack_wd       = pwdata_i[12:0];
		case (state)
			CISE_ST_IDLE: begin
				if (wr_acc && paddr_i == `CISE_CTRL_OFF) begin
					next_pc = pc + 13'h0001;
					case (op)
						CISE_OP_RETURN: begin
							next_sp    = sp - 1'b1;
							next_pc    = stack[sp - 1'b1];
							next_state = CISE_ST_RET2;
						end
						CISE_OP_RRC, CISE_OP_RLC: begin
							next_flags.c = rot.carry;
							if (dest) begin
								file_we = 1'b1;
								file_wa = fa;
								file_wd = rot.result;
							end else begin
								next_acc = rot.result;
							end
						end
						CISE_OP_SLEEP: begin
							next_flags.pd_n = 1'b0;
							next_flags.to_n = 1'b1;
							next_wdt_cnt    = 8'h00;
							next_wdt_pre    = 8'h00;
							next_state      = CISE_ST_SLP;
						end
						CISE_OP_LSUB: begin
							next_acc      = diff[7:0];
							next_flags.c  = !diff[8];
							next_flags.dc = !ndiff[4];
							next_flags.z  = (diff[7:0] == 8'h00);
						end
						default: begin
							next_pc = pc;
						end
					endcase
				end else if (wr_acc) begin
					case (paddr_i)
						`CISE_ACC_OFF:       next_acc = pwdata_i[7:0];
						`CISE_FILE_ADDR_OFF: next_file_addr = pwdata_i[6:0];
						`CISE_FILE_DATA_OFF: file_we = 1'b1;
						`CISE_PC_OFF:        next_pc = pwdata_i[12:0];
						`CISE_STACK_OFF: begin
							stack_we = 1'b1;
							next_sp  = sp + 1'b1;
						end
						`CISE_STATUS_OFF: begin
							next_flags.c  = pwdata_i[`CISE_ST_C];
							next_flags.dc = pwdata_i[`CISE_ST_DC];
							next_flags.z  = pwdata_i[`CISE_ST_Z];
						end
						default: begin
						end
					endcase
				end
			end
			CISE_ST_RET2: begin
				next_state = CISE_ST_IDLE;
			end
			CISE_ST_SLP: begin
				// The oscillator is modelled as stopped: nothing advances but the wake request.
				next_wdt_cnt = wdt_cnt;
				next_wdt_pre = wdt_pre;
				if (wr_acc && paddr_i == `CISE_CTRL_OFF && pwdata_i[`CISE_CTRL_WAKE_BIT]) begin
					next_state = CISE_ST_IDLE;
				end
			end
			default: begin
				next_state = CISE_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state     <= CISE_ST_IDLE;
			flags     <= cise_flags_s'(`CISE_STATUS_RST);
			acc       <= 8'h00;
			pc        <= 13'h0000;
			sp        <= '0;
			wdt_cnt   <= 8'h00;
			wdt_pre   <= 8'h00;
			file_addr <= 7'h00;
		end else begin
			state     <= next_state;
			flags     <= next_flags;
			acc       <= next_acc;
			pc        <= next_pc;
			sp        <= next_sp;
			wdt_cnt   <= next_wdt_cnt;
			wdt_pre   <= next_wdt_pre;
			file_addr <= next_file_addr;
		end
	end

	// Storage holds no reset; software initialises it before use.
	always_ff @(posedge core_clk_i) begin
		if (file_we) begin
			file_q[file_wa] <= file_wd;
		end
		if (stack_we) begin
			stack[sp] <= stack_wd;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_slverr = 1'b0;
		case (paddr_i)
			`CISE_CTRL_OFF:      next_prdata = 32'h0000_0000;
			`CISE_STATUS_OFF:    next_prdata = {25'h0, sleeping_o, state != CISE_ST_IDLE,
				flags.to_n, flags.pd_n, flags.z, flags.dc, flags.c};
			`CISE_ACC_OFF:       next_prdata = {24'h0, acc};
			`CISE_FILE_ADDR_OFF: next_prdata = {25'h0, file_addr};
			`CISE_FILE_DATA_OFF: next_prdata = {24'h0, file_q[file_addr]};
			`CISE_PC_OFF:        next_prdata = {19'h0, pc};
			`CISE_STACK_OFF:     next_prdata = {19'h0, stack[sp - 1'b1]};
			`CISE_WDT_OFF:       next_prdata = {16'h0, wdt_pre, wdt_cnt};
			default:             next_slverr = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (psel_i && !penable_i) begin
			prdata_o  <= next_prdata;
			pslverr_o <= next_slverr;
		end
	end
endmodule : cise_core

// ### sim/cise_core_monitor.sv
// Port checker for the instruction subset executor.
`timescale 1ns/1ps
module cise_core_monitor #(
	parameter int FILE_DEPTH  = 128,
	parameter int STACK_DEPTH = 16
) (
	input wire logic        core_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        sleeping_o
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic acc, ctl_w, bad;
	assign acc   = psel_i && penable_i;
	assign ctl_w = acc && pwrite_i && (paddr_i == 12'h000);
	assign bad   = (paddr_i > 12'h01C) || (paddr_i[1:0] != 2'h0);
	a_sleep_enter: assert property (ctl_w && pready_o && pwdata_i[2:0] == 3'h4 && !pwdata_i[5] |=> sleeping_o)
		else $error("sleep not entered");
	a_sleep_holds: assert property (sleeping_o && !(ctl_w && pready_o && pwdata_i[5]) |=> sleeping_o)
		else $error("sleep left without wake");
	a_wake_exit: assert property (sleeping_o && ctl_w && pready_o && pwdata_i[5] |=> !sleeping_o)
		else $error("wake ignored");
	a_sleep_stall: assert property (sleeping_o && ctl_w && !pwdata_i[5] |-> !pready_o)
		else $error("command run while asleep");
	a_err_unmapped: assert property (acc && bad |-> pslverr_o)
		else $error("no error on unmapped address");
	a_err_mapped: assert property (acc && !bad |-> !pslverr_o)
		else $error("error on mapped address");
	a_read_zero: assert property (acc && !pwrite_i && bad |-> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_ready_free: assert property (acc && !(pwrite_i && paddr_i == 12'h000) |-> pready_o)
		else $error("wait state on plain access");
	a_reset_awake: assert property ($fell(sys_rst_i) |-> !sleeping_o && !pslverr_o)
		else $error("not idle after reset");
	c_sleep: cover property (ctl_w && pready_o && pwdata_i[2:0] == 3'h4);
	c_wake: cover property (sleeping_o ##1 !sleeping_o);
	c_err: cover property (acc && pslverr_o);
	c_ret: cover property (ctl_w && pready_o && pwdata_i[2:0] == 3'h1);
endmodule : cise_core_monitor

bind cise_core cise_core_monitor #(.FILE_DEPTH(FILE_DEPTH), .STACK_DEPTH(STACK_DEPTH)) u_cise_core_monitor (
	.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .sleeping_o(sleeping_o));

// ### sim/cise_core_tb.sv
// Self-checking bench for the instruction subset executor.
`timescale 1ns/1ps
module cise_core_tb;
	import cise_pkg::*;
	logic        clk, rst, psel, pen, pwr, pready, pslverr, slp, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int          miscompares, n_compared;
	cise_core u_cise_core (.core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.sleeping_o(slp));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk
	// The master never assumes a latency; only the watchdog ends a stall.
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : bus
	task automatic t_unmapped;
		bus(1'b0, 12'h020, 32'h0);
		chk(32'(e), 32'h1);
		chk(q, 32'h0);
		bus(1'b0, 12'h004, 32'h0);
		chk(q, 32'h18);
	endtask : t_unmapped
	task automatic t_sub;
		logic [7:0] k[4] = '{8'h05, 8'h03, 8'h10, 8'hFF};
		logic [7:0] w[4] = '{8'h05, 8'h04, 8'h01, 8'h00};
		logic [7:0] r;
		for (int i = 0; i < 4; i++) begin
			r = k[i] - w[i];
			bus(1'b1, 12'h008, {24'h0, w[i]});
			bus(1'b1, 12'h000, {16'h0, k[i], 8'h05});
			bus(1'b0, 12'h008, 32'h0);
			chk(q, {24'h0, r});
			bus(1'b0, 12'h004, 32'h0);
			chk(q & 32'h7, {29'h0, r == 8'h00, w[i][3:0] <= k[i][3:0], w[i] <= k[i]});
		end
	endtask : t_sub
	task automatic t_rot;
		bus(1'b1, 12'h00C, 32'h7F);
		bus(1'b1, 12'h010, 32'hE6);
		bus(1'b1, 12'h004, 32'h0);
		bus(1'b1, 12'h000, 32'h007F_0003);
		bus(1'b0, 12'h008, 32'h0);
		chk(q, 32'hCC);
		bus(1'b0, 12'h010, 32'h0);
		chk(q, 32'hE6);
		bus(1'b0, 12'h004, 32'h0);
		chk(q & 32'h1F, 32'h19);
		bus(1'b1, 12'h000, 32'h007F_0012);
		bus(1'b0, 12'h010, 32'h0);
		chk(q, 32'hF3);
		bus(1'b0, 12'h008, 32'h0);
		chk(q, 32'hCC);
		bus(1'b0, 12'h004, 32'h0);
		chk(q & 32'h1F, 32'h18);
	endtask : t_rot
	task automatic t_ret;
		bus(1'b1, 12'h018, 32'h0123);
		bus(1'b1, 12'h000, 32'h1);
		bus(1'b0, 12'h014, 32'h0);
		chk(q, 32'h0123);
		bus(1'b0, 12'h004, 32'h0);
		chk(q & 32'h1F, 32'h18);
	endtask : t_ret
	// A command followed at once by a status read, so the read's setup edge sees the cycle after it.
	task automatic cmd_then_status(input logic [31:0] c);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= 1'b1;
		paddr <= 12'h000;
		pwdata <= c;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		pen <= 1'b0;
		pwr <= 1'b0;
		paddr <= 12'h004;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : cmd_then_status
	task automatic t_ret_busy;
		bus(1'b1, 12'h018, 32'h0456);
		cmd_then_status(32'h1);
		chk(q & 32'h3F, 32'h38);
		bus(1'b0, 12'h004, 32'h0);
		chk(q & 32'h3F, 32'h18);
		bus(1'b0, 12'h014, 32'h0);
		chk(q, 32'h0456);
		cmd_then_status(32'h007F_0003);
		chk(q & 32'h3F, 32'h19);
		bus(1'b0, 12'h008, 32'h0);
		chk(q, 32'hE6);
	endtask : t_ret_busy
	task automatic t_sleep;
		bus(1'b1, 12'h004, 32'h7);
		repeat (10) @(posedge clk);
		bus(1'b1, 12'h000, 32'h4);
		@(negedge clk);
		chk(32'(slp), 32'h1);
		bus(1'b0, 12'h004, 32'h0);
		chk(q & 32'h5F, 32'h57);
		bus(1'b0, 12'h01C, 32'h0);
		chk(q & 32'hFFFF, 32'h0);
		bus(1'b1, 12'h000, 32'h20);
		@(negedge clk);
		chk(32'(slp), 32'h0);
	endtask : t_sleep
	task automatic report_and_stop;
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		rst = 1'b1;
		{psel, pen, pwr, paddr, pwdata} = '0;
		miscompares = 0;
		n_compared = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_unmapped();
		t_sub();
		t_rot();
		t_ret();
		t_ret_busy();
		t_sleep();
		report_and_stop();
	end
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end
endmodule : cise_core_tb
